// [hdl/imfl_top.sv]
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
// Function
// - Each of nine interrupt sources has a disable bit that blocks its handler.
// - A set disable bit beats the global enable.
// - With its disable bit clear, a request from a source is accepted.
// - An accepted interrupt starts its handler at once while globally enabled.
// - While globally disabled, accepted interrupts stay pending until re-enabled.
// - One counter disable bit blocks all six counter interrupt sources.
// - In catch mode, four latches set on rising edges of inputs 0 to 3.
// - Configuration fault raises its flag and records its code.
// - Communication fault raises its flag and records its detail code.
// - Latched operation error flag and code survive the live flag clearing.
// - Stop to run clears live flags but keeps the latched error and code.
// - With bus check enabled, a bus failure stores the fixed code and flag.
module imfl_top (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Interrupt requests
   input wire logic [5:0] input_irq_req,
   input wire logic [2:0] timer_irq_req,
   input wire logic [5:0] counter_irq_req,
   // Pulse catch inputs
   input wire logic [3:0] edge_latch_in,
   // Operating mode and fault reports
   input wire logic run_mode,
   input wire logic io_config_fault,
   input wire logic [15:0] io_config_code,
   input wire logic comm_fault,
   input wire logic [15:0] comm_code,
   input wire logic calc_fault,
   input wire logic [15:0] calc_code,
   input wire logic bus_fault,
   // Handler starts
   output logic [8:0] handler_start_q,
   output logic [5:0] counter_start_q
);

   ////////////////////////////////////////////////////////////////////////////
   // Register bus
   imfl_reg_if rif ();

   imfl_axil_slave u_slave (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .rif(rif)
   );

   logic [11:0] mask_q;
   logic gie_q;
   logic [8:0] pend_q;
   logic [5:0] cnt_pend_q;
   logic [3:0] catch_q;
   logic [3:0] edge_prev_q;
   logic [4:0] flags_q;
   logic [15:0] io_config_fault_code, hw_fault_code, comm_fault_code, calc_fault_latched_code;
   logic run_prev_q;
   logic [31:0] wbits;
   logic wr_mask, wr_gie, wr_catch, wr_flags;
   logic [8:0] src_req, src_mask, src_acc;
   logic [5:0] cnt_acc;
   logic counter_irq_mask, bus_check_enable, catch_mode, to_run;
   logic [14:0] eligible, pick;
   logic [4:0] flag_set, flag_clr;

   // Lowest set bit wins the dispatch slot
   function automatic logic [14:0] lowest_one(input logic [14:0] x);
      return x & (~x + 15'h0001);
   endfunction : lowest_one

   ////////////////////////////////////////////////////////////////////////////
   // Write decode, byte strobes honoured
   assign wbits = rif.wdata & imfl_pkg::strb_mask(rif.wstrb);
   assign wr_mask = rif.wr && (rif.waddr == imfl_pkg::MASK_OFF);
   assign wr_gie = rif.wr && (rif.waddr == imfl_pkg::GIE_OFF);
   assign wr_catch = rif.wr && (rif.waddr == imfl_pkg::CATCH_OFF);
   assign wr_flags = rif.wr && (rif.waddr == imfl_pkg::FLAGS_OFF);

   // Mask register fields
   assign src_mask = mask_q[8:0];
   assign counter_irq_mask = mask_q[imfl_pkg::MASK_CNT_BIT];
   assign bus_check_enable = mask_q[imfl_pkg::MASK_BUSCHK_BIT];
   assign catch_mode = mask_q[imfl_pkg::MASK_CATCH_BIT];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mask_q <= imfl_pkg::MASK_RST;
      else if (wr_mask)
         mask_q <= wbits[11:0];
   end

   // Global enable, set by the enable command and cleared by the disable command
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         gie_q <= 1'b0;
      else if (wr_gie && wbits[imfl_pkg::GIE_CLR_BIT])
         gie_q <= 1'b0;
      else if (wr_gie && wbits[imfl_pkg::GIE_SET_BIT])
         gie_q <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Acceptance: masked requests are dropped, unmasked ones become pending
   assign src_req = {timer_irq_req, input_irq_req};
   assign src_acc = src_req & ~src_mask;
   assign cnt_acc = counter_irq_req & {6{!counter_irq_mask}};
   // Only unmasked pending sources may run, whatever the global enable says
   assign eligible = {cnt_pend_q & {6{!counter_irq_mask}}, pend_q & ~src_mask};
   assign pick = gie_q ? lowest_one(eligible) : 15'h0000;

   // Pending bits; a new request beats the clear of its own dispatch
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pend_q <= 9'h000;
         cnt_pend_q <= 6'h00;
      end
      else
      begin
         pend_q <= (pend_q & ~pick[8:0]) | src_acc;
         cnt_pend_q <= (cnt_pend_q & ~pick[14:9]) | cnt_acc;
      end
   end

   // Handler start pulses, one source per cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         handler_start_q <= 9'h000;
         counter_start_q <= 6'h00;
      end
      else
      begin
         handler_start_q <= pick[8:0];
         counter_start_q <= pick[14:9];
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_mask_blocks_start: assert property (
      (handler_start_q & $past(src_mask)) == 9'h000)
      else $error("masked source started its handler");

   a_gie_gates_start: assert property (
      (handler_start_q != 9'h000 || counter_start_q != 6'h00) |-> $past(gie_q))
      else $error("handler started while globally disabled");

   a_accept_request: assert property (
      (input_irq_req[0] && !src_mask[0]) |=> pend_q[0])
      else $error("unmasked request not accepted");

   a_drop_masked: assert property (
      (input_irq_req[0] && src_mask[0] && !pend_q[0]) |=> !pend_q[0])
      else $error("masked request was queued");

   sequence s_ready;
      gie_q && ((pend_q & ~src_mask) != 9'h000);
   endsequence

   a_prompt_start: assert property (
      s_ready |=> (handler_start_q != 9'h000))
      else $error("enabled pending interrupt not started");

   a_counter_blocked: assert property (
      (counter_start_q != 6'h00) |-> !$past(counter_irq_mask))
      else $error("counter handler started while blocked");

   ////////////////////////////////////////////////////////////////////////////
   // Pulse catch latches, cleared by writing ones
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         edge_prev_q <= 4'h0;
      else
         edge_prev_q <= edge_latch_in;
   end

   for (genvar i = 0; i < 4; i++)
   begin : g_catch
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            catch_q[i] <= 1'b0;
         else if (catch_mode && edge_latch_in[i] && !edge_prev_q[i])
            catch_q[i] <= 1'b1;
         else if (wr_catch && wbits[i])
            catch_q[i] <= 1'b0;
      end
   end

   a_catch_edge: assert property (
      (catch_mode && edge_latch_in[3] && !edge_prev_q[3]) |=> catch_q[3] ##1
         (catch_q[3] || $past(wr_catch)))
      else $error("rising edge not caught");

   ////////////////////////////////////////////////////////////////////////////
   // Error flags: events set, stop to run or software clears, set wins
   assign to_run = run_mode && !run_prev_q;
   assign flag_set = {calc_fault, calc_fault, comm_fault, bus_check_enable && bus_fault,
      io_config_fault};
   assign flag_clr = (wr_flags ? wbits[4:0] : 5'h00) |
      (to_run ? imfl_pkg::FLAGS_RUN_CLR : 5'h00);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         run_prev_q <= 1'b0;
         flags_q <= imfl_pkg::FLAGS_RST;
      end
      else
      begin
         run_prev_q <= run_mode;
         flags_q <= flag_set | (flags_q & ~flag_clr);
      end
   end

   // Fault codes captured with their flags; the latched code outlives mode changes
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         io_config_fault_code <= imfl_pkg::CODE_RST;
         hw_fault_code <= imfl_pkg::CODE_RST;
         comm_fault_code <= imfl_pkg::CODE_RST;
         calc_fault_latched_code <= imfl_pkg::CODE_RST;
      end
      else
      begin
         if (io_config_fault)
            io_config_fault_code <= io_config_code;
         if (bus_check_enable && bus_fault)
            hw_fault_code <= imfl_pkg::BUS_ERR_CODE;
         if (comm_fault)
            comm_fault_code <= comm_code;
         if (calc_fault)
            calc_fault_latched_code <= calc_code;
      end
   end

   a_cfg_code: assert property (
      io_config_fault |=> flags_q[imfl_pkg::FLAG_CFG] &&
         io_config_fault_code == $past(io_config_code))
      else $error("configuration fault not recorded");

   a_comm_code: assert property (
      comm_fault |=> flags_q[imfl_pkg::FLAG_COMM] && comm_fault_code == $past(comm_code))
      else $error("communication fault not recorded");

   a_bus_check: assert property (
      (bus_check_enable && bus_fault) |=> flags_q[imfl_pkg::FLAG_HW] &&
         hw_fault_code == imfl_pkg::BUS_ERR_CODE)
      else $error("bus failure not recorded");

   sequence s_to_run_quiet;
      to_run && !calc_fault && !(wr_flags && wbits[imfl_pkg::FLAG_CALC_LATCH]);
   endsequence

   a_latch_survives: assert property (
      s_to_run_quiet |=> !flags_q[imfl_pkg::FLAG_CALC] &&
         $stable(flags_q[imfl_pkg::FLAG_CALC_LATCH]) && $stable(calc_fault_latched_code))
      else $error("stop to run disturbed the latched error");

   ////////////////////////////////////////////////////////////////////////////
   // Read mux
   always_comb
   begin
      rif.rdata = 32'h0000_0000;
      unique case (rif.raddr)
         imfl_pkg::MASK_OFF: rif.rdata = {20'h00000, mask_q};
         imfl_pkg::GIE_OFF: rif.rdata = {31'h0000_0000, gie_q};
         imfl_pkg::PEND_OFF: rif.rdata = {17'h00000, cnt_pend_q, pend_q};
         imfl_pkg::CATCH_OFF: rif.rdata = {28'h000_0000, catch_q};
         imfl_pkg::FLAGS_OFF: rif.rdata = {27'h000_0000, flags_q};
         imfl_pkg::CFG_CODE_OFF: rif.rdata = {16'h0000, io_config_fault_code};
         imfl_pkg::HW_CODE_OFF: rif.rdata = {16'h0000, hw_fault_code};
         imfl_pkg::COMM_CODE_OFF: rif.rdata = {16'h0000, comm_fault_code};
         imfl_pkg::CALC_CODE_OFF: rif.rdata = {16'h0000, calc_fault_latched_code};
         default: rif.rdata = 32'h0000_0000;
      endcase
   end

endmodule : imfl_top

// [common/imfl_pkg.sv]
package imfl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] MASK_OFF = 8'h00;
   localparam logic [7:0] GIE_OFF = 8'h04;
   localparam logic [7:0] PEND_OFF = 8'h08;
   localparam logic [7:0] CATCH_OFF = 8'h0c;
   localparam logic [7:0] FLAGS_OFF = 8'h10;
   localparam logic [7:0] CFG_CODE_OFF = 8'h14;
   localparam logic [7:0] HW_CODE_OFF = 8'h18;
   localparam logic [7:0] COMM_CODE_OFF = 8'h1c;
   localparam logic [7:0] CALC_CODE_OFF = 8'h20;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int MASK_CNT_BIT = 9;
   localparam int MASK_BUSCHK_BIT = 10;
   localparam int MASK_CATCH_BIT = 11;
   localparam int GIE_SET_BIT = 0;
   localparam int GIE_CLR_BIT = 1;
   localparam int FLAG_CFG = 0;
   localparam int FLAG_HW = 1;
   localparam int FLAG_COMM = 2;
   localparam int FLAG_CALC = 3;
   localparam int FLAG_CALC_LATCH = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and fixed codes
   localparam logic [11:0] MASK_RST = 12'h000;
   localparam logic [4:0] FLAGS_RST = 5'h00;
   localparam logic [4:0] FLAGS_RUN_CLR = 5'h0f;
   localparam logic [15:0] CODE_RST = 16'h0000;
   localparam logic [15:0] BUS_ERR_CODE = 16'h17d7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Address decode shared by the write and read paths
   function automatic logic reg_hit(input logic [7:0] addr);
      return (addr == MASK_OFF) || (addr == GIE_OFF) || (addr == PEND_OFF) ||
         (addr == CATCH_OFF) || (addr == FLAGS_OFF) || (addr == CFG_CODE_OFF) ||
         (addr == HW_CODE_OFF) || (addr == COMM_CODE_OFF) || (addr == CALC_CODE_OFF);
   endfunction : reg_hit

   // Expand byte strobes to a bit mask
   function automatic logic [31:0] strb_mask(input logic [3:0] strb);
      return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction : strb_mask

endpackage : imfl_pkg

// [common/imfl_reg_if.sv]
`timescale 1ns/1ns
interface imfl_reg_if;
   logic wr;
   logic [7:0] waddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic rd;
   logic [7:0] raddr;
   logic [31:0] rdata;

   modport bus (output wr, output waddr, output wdata, output wstrb, output rd, output raddr,
      input rdata);
   modport core (input wr, input waddr, input wdata, input wstrb, input rd, input raddr,
      output rdata);
endinterface : imfl_reg_if

// [hdl/imfl_axil_slave.sv]
`timescale 1ns/1ns
module imfl_axil_slave (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address and data
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // Write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // Read address and data
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Register strobes toward the core
   imfl_reg_if.bus rif
);

   ////////////////////////////////////////////////////////////////////////////
   logic aw_hs, w_hs, ar_hs, have_aw_q, have_w_q, have_aw_d, have_w_d;
   logic do_wr, bvalid_d, rvalid_d;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   // Handshakes and next states of the write and read sides
   assign aw_hs = s_axi_awvalid && s_axi_awready;
   assign w_hs = s_axi_wvalid && s_axi_wready;
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   assign do_wr = have_aw_q && have_w_q && !s_axi_bvalid;
   assign have_aw_d = (have_aw_q && !do_wr) || aw_hs;
   assign have_w_d = (have_w_q && !do_wr) || w_hs;
   assign bvalid_d = do_wr || (s_axi_bvalid && !s_axi_bready);
   assign rvalid_d = ar_hs || (s_axi_rvalid && !s_axi_rready);

   // Strobes to the core; reads are decoded in the handshake cycle
   assign rif.wr = do_wr;
   assign rif.waddr = awaddr_q;
   assign rif.wdata = wdata_q;
   assign rif.wstrb = wstrb_q;
   assign rif.rd = ar_hs;
   assign rif.raddr = s_axi_araddr;

   // Write channel, address and data taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         have_aw_q <= 1'b0;
         have_w_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= imfl_pkg::RESP_OKAY;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end
      else
      begin
         have_aw_q <= have_aw_d;
         have_w_q <= have_w_d;
         s_axi_awready <= !have_aw_d && !bvalid_d;
         s_axi_wready <= !have_w_d && !bvalid_d;
         s_axi_bvalid <= bvalid_d;
         if (aw_hs)
            awaddr_q <= s_axi_awaddr;
         if (w_hs)
         begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_wr)
            s_axi_bresp <= imfl_pkg::reg_hit(awaddr_q) ? imfl_pkg::RESP_OKAY :
               imfl_pkg::RESP_SLVERR;
      end
   end

   // Read channel, data captured at the address handshake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= imfl_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !rvalid_d;
         s_axi_rvalid <= rvalid_d;
         if (ar_hs)
         begin
            s_axi_rdata <= rif.rdata;
            s_axi_rresp <= imfl_pkg::reg_hit(s_axi_araddr) ? imfl_pkg::RESP_OKAY :
               imfl_pkg::RESP_SLVERR;
         end
      end
   end

endmodule : imfl_axil_slave

// [verif/imfl_env_model.sv]
`timescale 1ns/1ns
module imfl_env_model (
   // Clock
   input wire logic aclk,
   // Interrupt requests
   output logic [5:0] input_irq_req,
   output logic [2:0] timer_irq_req,
   output logic [5:0] counter_irq_req,
   // Catch inputs and mode
   output logic [3:0] edge_latch_in,
   output logic run_mode,
   // Fault reports
   output logic io_config_fault,
   output logic [15:0] io_config_code,
   output logic comm_fault,
   output logic [15:0] comm_code,
   output logic calc_fault,
   output logic [15:0] calc_code,
   output logic bus_fault
);
   // Quiet levels at time zero
   initial
   begin
      {counter_irq_req, timer_irq_req, input_irq_req} = 15'h0000;
      {edge_latch_in, run_mode} = 5'h00;
      {bus_fault, calc_fault, comm_fault, io_config_fault} = 4'h0;
      {io_config_code, comm_code, calc_code} = 48'h0;
   end

   // One-cycle request from source s, counters from 9 up
   task automatic irq(input int s);
      @(posedge aclk);
      {counter_irq_req, timer_irq_req, input_irq_req} <= 15'h0001 << s;
      @(posedge aclk);
      {counter_irq_req, timer_irq_req, input_irq_req} <= 15'h0000;
   endtask : irq

   // One-cycle fault event; codes turn to garbage once the event ends
   task automatic flt(input int k, input logic [15:0] c);
      @(posedge aclk);
      {bus_fault, calc_fault, comm_fault, io_config_fault} <= 4'h1 << k;
      {io_config_code, comm_code, calc_code} <= {c, c, c};
      @(posedge aclk);
      {bus_fault, calc_fault, comm_fault, io_config_fault} <= 4'h0;
      {io_config_code, comm_code, calc_code} <= {~c, ~c, ~c};
   endtask : flt

   // Catch input levels and run mode
   task automatic lvl(input logic [3:0] e, input logic r);
      @(posedge aclk);
      edge_latch_in <= e;
      run_mode <= r;
   endtask : lvl
endmodule : imfl_env_model

// [verif/interrupt_mask_and_error_flags_test.sv]
`timescale 1ns/1ns
module interrupt_mask_and_error_flags_test;
   logic aclk, aresetn;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
   logic [3:0] s_axi_wstrb, edge_latch_in;
   logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
   logic [5:0] input_irq_req, counter_irq_req, counter_start_q;
   logic [2:0] timer_irq_req;
   logic run_mode, io_config_fault, comm_fault, calc_fault, bus_fault;
   logic [15:0] io_config_code, comm_code, calc_code;
   logic [8:0] handler_start_q;
   logic [14:0] sh;
   int n_fail, checked, cyc;

   imfl_top uut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp, .input_irq_req, .timer_irq_req, .counter_irq_req, .edge_latch_in,
      .run_mode, .io_config_fault, .io_config_code, .comm_fault, .comm_code, .calc_fault,
      .calc_code, .bus_fault, .handler_start_q, .counter_start_q);
   imfl_env_model m (.aclk, .input_irq_req, .timer_irq_req, .counter_irq_req,
      .edge_latch_in, .run_mode, .io_config_fault, .io_config_code, .comm_fault,
      .comm_code, .calc_fault, .calc_code, .bus_fault);

   ////////////////////////////////////////////////////////////////////////////
   // Clock, start collector and hang guard
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(negedge aclk) sh = sh | {counter_start_q, handler_start_q};
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Write; ready levels are looked at mid-cycle, equal to the edge sample
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      {aw, w, b} = 3'h0;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (!b)
      begin
         @(negedge aclk);
         aw = aw | (s_axi_awvalid & s_axi_awready);
         w = w | (s_axi_wvalid & s_axi_wready);
         b = s_axi_bvalid;
         wr_resp = s_axi_bresp;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] a);
      logic ar, r;
      {ar, r} = 2'h0;
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      while (!r)
      begin
         @(negedge aclk);
         ar = ar | (s_axi_arvalid & s_axi_arready);
         r = s_axi_rvalid;
         {rd_q, rd_resp} = {s_axi_rdata, s_axi_rresp};
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask : axr

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      axr(a);
      chk(nm, rd_q, e);
   endtask : rdc

   // Clear collector, fire one source, collect starts over four cycles
   task automatic fire(input int s, input logic [14:0] e);
      @(posedge aclk);
      sh = 15'h0000;
      m.irq(s);
      repeat (4) @(posedge aclk);
      chk("starts", {17'h0, sh}, {17'h0, e});
   endtask : fire

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_base();
      rdc("mask", imfl_pkg::MASK_OFF, 32'h0);
      chk("rresp", {30'h0, rd_resp}, {30'h0, imfl_pkg::RESP_OKAY});
      axw(8'h24, 32'h1);
      chk("bresp", {30'h0, wr_resp}, {30'h0, imfl_pkg::RESP_SLVERR});
      axr(8'h24);
      chk("rresp", {30'h0, rd_resp}, {30'h0, imfl_pkg::RESP_SLVERR});
   endtask : t_base

   task automatic t_enable();
      axw(imfl_pkg::GIE_OFF, 32'h1);
      chk("bresp", {30'h0, wr_resp}, {30'h0, imfl_pkg::RESP_OKAY});
      fire(3, 15'h0008);
      fire(8, 15'h0100);
   endtask : t_enable

   // Each of the nine source masks with the global enable on; the dropped request is not replayed
   task automatic t_mask();
      for (int i = 0; i < 9; i++)
      begin
         axw(imfl_pkg::MASK_OFF, 32'h1 << i);
         fire(i, 15'h0000);
      end
      axw(imfl_pkg::MASK_OFF, 32'h1ff);
      fire(7, 15'h0000);
      rdc("pend", imfl_pkg::PEND_OFF, 32'h0);
      sh = 15'h0000;
      axw(imfl_pkg::MASK_OFF, 32'h0);
      repeat (4) @(posedge aclk);
      chk("replay", {17'h0, sh}, 32'h0);
   endtask : t_mask

   task automatic t_gdis();
      axw(imfl_pkg::GIE_OFF, 32'h2);
      fire(0, 15'h0000);
      rdc("pend", imfl_pkg::PEND_OFF, 32'h1);
      sh = 15'h0000;
      axw(imfl_pkg::GIE_OFF, 32'h1);
      repeat (4) @(posedge aclk);
      chk("late start", {17'h0, sh}, 32'h1);
      rdc("pend", imfl_pkg::PEND_OFF, 32'h0);
   endtask : t_gdis

   task automatic t_cnt();
      axw(imfl_pkg::MASK_OFF, 32'h200);
      for (int i = 9; i < 15; i++) fire(i, 15'h0000);
      axw(imfl_pkg::MASK_OFF, 32'h0);
      fire(14, 15'h4000);
   endtask : t_cnt

   task automatic t_catch();
      axw(imfl_pkg::MASK_OFF, 32'h800);
      m.lvl(4'h9, 1'b0);
      m.lvl(4'h0, 1'b0);
      rdc("catch", imfl_pkg::CATCH_OFF, 32'h9);
      axw(imfl_pkg::CATCH_OFF, 32'h9);
      rdc("catch", imfl_pkg::CATCH_OFF, 32'h0);
      m.lvl(4'h2, 1'b0);
      rdc("catch", imfl_pkg::CATCH_OFF, 32'h2);
   endtask : t_catch

   task automatic t_flt();
      m.flt(0, 16'h1234);
      m.flt(1, 16'h00a5);
      m.flt(2, 16'h0bad);
      rdc("flags", imfl_pkg::FLAGS_OFF, 32'h1d);
      rdc("cfg code", imfl_pkg::CFG_CODE_OFF, 32'h1234);
      rdc("comm code", imfl_pkg::COMM_CODE_OFF, 32'h00a5);
      axw(imfl_pkg::FLAGS_OFF, 32'h8);
      rdc("flags", imfl_pkg::FLAGS_OFF, 32'h15);
      rdc("calc code", imfl_pkg::CALC_CODE_OFF, 32'h0bad);
      m.lvl(4'h0, 1'b1);
      repeat (3) @(posedge aclk);
      rdc("flags", imfl_pkg::FLAGS_OFF, 32'h10);
      rdc("calc code", imfl_pkg::CALC_CODE_OFF, 32'h0bad);
   endtask : t_flt

   task automatic t_bus();
      m.flt(3, 16'h0000);
      rdc("flags", imfl_pkg::FLAGS_OFF, 32'h10);
      axw(imfl_pkg::MASK_OFF, 32'h400);
      m.flt(3, 16'h0000);
      rdc("flags", imfl_pkg::FLAGS_OFF, 32'h12);
      rdc("hw code", imfl_pkg::HW_CODE_OFF, {16'h0, imfl_pkg::BUS_ERR_CODE});
   endtask : t_bus

   ////////////////////////////////////////////////////////////////////////////
   // Verdict
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   // Main sequence
   initial
   begin
      {n_fail, checked} = '0;
      sh = 15'h0000;
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_base();
      t_enable();
      t_mask();
      t_gdis();
      t_cnt();
      t_catch();
      t_flt();
      t_bus();
      complete_run();
   end
endmodule : interrupt_mask_and_error_flags_test
